// ---- src/field_memory_path_control.sv ----
/*
 * Field memory path control: field-rate control registers written from the
 * serial control bus decoder, driving field memory write paths, line tree
 * routing, vertical offsets and prediction memory writes.
 * Assumes the bus decoder and the video pipeline share REF_CLK; the field
 * start marker and the progressive strap come from pins and are synchronised.
 */
// What this block does
// - Combined enable writes second and third memories
// - Swap routes current field to right tree
// - Vector offset decodes to zero, plus, minus
// - Noise offset applies before swap action
// - Left parity gives left tree interlace phase
// - Original luma update else recirculate second memory
// - Prediction memory written only when fill updates
`timescale 1ns/100ps
module field_memory_path_control (
    input wire logic REF_CLK, // System clock, 200 MHz
    input wire logic ARST_N, // Asynchronous reset, active low
    input wire logic REG_WR, // Register write strobe from bus decoder
    input wire logic [8:0] REG_ADDR, // Register address
    input wire logic [7:0] REG_WDATA, // Register write data
    input wire logic FIELD_START, // Output field start marker, pin
    input wire logic PROGRESSIVE, // Progressive output mode, pin level
    input wire logic PIX_VALID, // Pixel strobe of the memory pipeline
    input wire fmpc_pkg::pixel_t DEINT_PIX, // De-interlacer output pixel
    input wire logic [7:0] FM2_RD_LUMA, // Luma just read from second memory
    input wire logic [7:0] FM3_RD_LUMA, // Luma just read from third memory
    input wire logic [7:0] FM1_LINE, // Current field line data
    input wire logic [7:0] FRAME_LINE, // Stored frame line data
    input wire logic EST_VALID, // New motion estimate ready
    input wire logic [7:0] EST_DATA, // Motion estimate
    output logic NEW_FIELD_FLAG, // New field at first memory output
    output logic FM2_WE, // Second memory write enable
    output fmpc_pkg::pixel_t FM2_WR_PIX, // Second memory write pixel
    output logic FM3_WE, // Third memory write enable
    output fmpc_pkg::pixel_t FM3_WR_PIX, // Third memory write pixel
    output logic [7:0] LEFT_TREE_DATA, // Left line tree write data
    output logic [7:0] RIGHT_TREE_DATA, // Right line tree write data
    output logic [1:0] VEC_OFFSET, // Signed right-to-left offset, lines
    output logic [1:0] DNR_OFFSET, // Signed pre-swap noise offset, lines
    output logic LEFT_PARITY, // Interlace phase of left tree field
    output logic FIRST_ODD, // Parity of first memory output field
    output logic TPM_WE, // Prediction memory write enable
    output logic [7:0] TPM_WR_DATA // Prediction memory write data
);
    // Code 2 is unused: it is read as no offset rather than a wild shift
    function automatic logic [1:0] offs_decode(input logic [1:0] code);
        return (code == fmpc_pkg::OFFS_PLUS || code == fmpc_pkg::OFFS_MINUS) ?
            code : fmpc_pkg::OFFS_ZERO;
    endfunction

    logic fs_s1_q, fs_s2_q, fs_s3_q, pr_s1_q, pr_s2_q;
    fmpc_pkg::path_ctl_t path_sh_q, path_q;
    fmpc_pkg::write_ctl_t wctl_sh_q, wctl_q;
    logic field_edge;
    wire wr_path = REG_WR && REG_ADDR == fmpc_pkg::ADDR_PATH_CONTROL;
    wire wr_wctl = REG_WR && REG_ADDR == fmpc_pkg::ADDR_FIELD_MEMORY_WRITE_CONTROL;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fs_s1_q <= 1'b0;
            fs_s2_q <= 1'b0;
            fs_s3_q <= 1'b0;
            pr_s1_q <= 1'b0;
            pr_s2_q <= 1'b0;
        end else begin
            fs_s1_q <= FIELD_START;
            fs_s2_q <= fs_s1_q;
            fs_s3_q <= fs_s2_q;
            pr_s1_q <= PROGRESSIVE;
            pr_s2_q <= pr_s1_q;
        end
    end
    assign field_edge = fs_s2_q && !fs_s3_q;

    // Field-rate registers: writes land in a shadow and take effect at the
    // next field start, so one field never sees a half-updated setting.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            path_sh_q <= fmpc_pkg::PATH_CONTROL_RESET;
            wctl_sh_q <= fmpc_pkg::WRITE_CONTROL_RESET;
            path_q <= fmpc_pkg::PATH_CONTROL_RESET;
            wctl_q <= fmpc_pkg::WRITE_CONTROL_RESET;
        end else begin
            if (wr_path)
                path_sh_q <= {REG_WDATA[7:3], 3'h0};
            if (wr_wctl)
                wctl_sh_q <= {2'h0, REG_WDATA[5:0]};
            if (field_edge) begin
                path_q <= wr_path ? {REG_WDATA[7:3], 3'h0} : path_sh_q;
                wctl_q <= wr_wctl ? {2'h0, REG_WDATA[5:0]} : wctl_sh_q;
            end
        end
    end

    wire comb_we = PIX_VALID && path_q.combined_memory_write_enable;
    wire fmpc_pkg::pixel_t fm2_d = '{
        luma: wctl_q.original_memory_luma_update ? DEINT_PIX.luma : FM2_RD_LUMA,
        chroma: DEINT_PIX.chroma};
    wire fmpc_pkg::pixel_t fm3_d = '{
        luma: wctl_q.interpolated_memory_luma_update ? DEINT_PIX.luma : FM3_RD_LUMA,
        chroma: DEINT_PIX.chroma};
    wire swap = path_q.line_tree_swap;
    wire [7:0] left_d = swap ? FRAME_LINE : FM1_LINE;
    wire [7:0] right_d = swap ? FM1_LINE : FRAME_LINE;
    wire tpm_we_d = EST_VALID && wctl_q.prediction_fill;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            NEW_FIELD_FLAG <= fmpc_pkg::NEW_FIELD_RESET;
            FM2_WE <= 1'b0;
            FM3_WE <= 1'b0;
            FM2_WR_PIX <= '0;
            FM3_WR_PIX <= '0;
            LEFT_TREE_DATA <= 8'h00;
            RIGHT_TREE_DATA <= 8'h00;
            VEC_OFFSET <= fmpc_pkg::OFFS_ZERO;
            DNR_OFFSET <= fmpc_pkg::OFFS_ZERO;
            LEFT_PARITY <= 1'b0;
            FIRST_ODD <= 1'b0;
            TPM_WE <= 1'b0;
            TPM_WR_DATA <= 8'h00;
        end else begin
            if (field_edge)
                NEW_FIELD_FLAG <= pr_s2_q ? 1'b1 : !NEW_FIELD_FLAG;
            FM2_WE <= comb_we;
            FM3_WE <= comb_we;
            FM2_WR_PIX <= fm2_d;
            FM3_WR_PIX <= fm3_d;
            LEFT_TREE_DATA <= left_d;
            RIGHT_TREE_DATA <= right_d;
            VEC_OFFSET <= offs_decode(path_q.vertical_vector_offset);
            // Taken against the unswapped trees; the swap only reroutes data
            DNR_OFFSET <= offs_decode(wctl_q.noise_reduction_vertical_offset);
            LEFT_PARITY <= wctl_q.left_tree_parity;
            FIRST_ODD <= path_q.first_memory_odd_parity;
            TPM_WE <= tpm_we_d;
            TPM_WR_DATA <= EST_DATA;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    flag_doubling_a: assert property (
        field_edge && !pr_s2_q |=> NEW_FIELD_FLAG != $past(NEW_FIELD_FLAG))
        else $error("field flag did not toggle");
    flag_progressive_a: assert property (
        field_edge && pr_s2_q |=> NEW_FIELD_FLAG)
        else $error("field flag not high in progressive");
    flag_steady_a: assert property (
        !field_edge |=> $stable(NEW_FIELD_FLAG))
        else $error("field flag moved between fields");
    memory_write_a: assert property (
        FM2_WE == FM3_WE && FM2_WE == $past(PIX_VALID &&
            path_q.combined_memory_write_enable))
        else $error("memory write enables wrong");
    tree_swap_a: assert property (
        swap |=> RIGHT_TREE_DATA == $past(FM1_LINE) && LEFT_TREE_DATA == $past(FRAME_LINE))
        else $error("swap routing wrong");
    // Legal codes pass through unchanged; the unused code must come out as no offset
    vec_offset_a: assert property (
        ##1 VEC_OFFSET == (($past(path_q.vertical_vector_offset) == 2'h2) ?
            fmpc_pkg::OFFS_ZERO : $past(path_q.vertical_vector_offset)))
        else $error("vector offset decode wrong");
    dnr_offset_a: assert property (
        wctl_q.noise_reduction_vertical_offset == fmpc_pkg::OFFS_MINUS
            |=> DNR_OFFSET == fmpc_pkg::OFFS_MINUS)
        else $error("noise offset not applied");
    left_parity_a: assert property (
        ##1 LEFT_PARITY == $past(wctl_q.left_tree_parity))
        else $error("left parity wrong");
    orig_luma_a: assert property (
        !wctl_q.original_memory_luma_update |=> FM2_WR_PIX.luma == $past(FM2_RD_LUMA))
        else $error("second memory not recirculated");
    intp_luma_a: assert property (
        wctl_q.interpolated_memory_luma_update |=> FM3_WR_PIX.luma == $past(DEINT_PIX.luma))
        else $error("third memory not updated");
    pred_keep_a: assert property (
        !wctl_q.prediction_fill |=> !TPM_WE)
        else $error("prediction memory written on keep");
    field_apply_a: assert property (
        !field_edge |=> $stable(path_q) && $stable(wctl_q))
        else $error("control changed mid-field");

    swap_cover: cover property (wr_path && REG_WDATA[fmpc_pkg::POS_TREE_SWAP] ##[1:20] field_edge);
    toggle_cover: cover property (field_edge && !pr_s2_q ##[1:50] field_edge);
    keep_cover: cover property (EST_VALID && !wctl_q.prediction_fill);
    recirc_cover: cover property (comb_we && !wctl_q.original_memory_luma_update);
endmodule

// ---- src/fmpc_pkg.sv ----
/*
 * Package for the field memory path control block: register offsets,
 * field positions, reset values and the packed control words.
 * Assumes one system clock; nothing else.
 */
package fmpc_pkg;
    localparam int ADDR_W = 9;
    localparam logic [8:0] ADDR_PATH_CONTROL = 9'h027;
    localparam logic [8:0] ADDR_FIELD_MEMORY_WRITE_CONTROL = 9'h028;

    // Field positions of the path control word
    localparam int POS_NEW_FIELD = 2;
    localparam int POS_COMBINED_WE = 3;
    localparam int POS_FIRST_ODD = 4;
    localparam int POS_TREE_SWAP = 5;
    localparam int POS_VEC_OFFS = 6;
    // Field positions of the field memory write control word
    localparam int POS_LEFT_PARITY = 0;
    localparam int POS_ORIG_UPDATE = 1;
    localparam int POS_INTP_UPDATE = 2;
    localparam int POS_PRED_FILL = 3;
    localparam int POS_DNR_OFFS = 4;

    localparam logic [7:0] PATH_CONTROL_RESET = 8'h00;
    localparam logic [7:0] WRITE_CONTROL_RESET = 8'h00;
    localparam logic NEW_FIELD_RESET = 1'b0;

    // Two-bit offset codes in frame lines
    localparam logic [1:0] OFFS_ZERO = 2'h0;
    localparam logic [1:0] OFFS_PLUS = 2'h1;
    localparam logic [1:0] OFFS_MINUS = 2'h3;

    typedef struct packed {
        logic [1:0] vertical_vector_offset;
        logic line_tree_swap;
        logic first_memory_odd_parity;
        logic combined_memory_write_enable;
        logic [2:0] unused;
    } path_ctl_t;

    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] noise_reduction_vertical_offset;
        logic prediction_fill;
        logic interpolated_memory_luma_update;
        logic original_memory_luma_update;
        logic left_tree_parity;
    } write_ctl_t;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } pixel_t;
endpackage

// ---- tb/control_software.sv ----
/* Control software model: writes rule-compliant field-rate control bytes over the
   register write strobe. Assumes the block samples writes on the rising REF_CLK. */
`timescale 1ns/100ps
module control_software (
    input wire logic REF_CLK, // System clock
    output logic REG_WR, // Write strobe
    output logic [8:0] REG_ADDR, // Register address
    output logic [7:0] REG_WDATA // Write data
);
    logic [7:0] path_byte;
    logic [7:0] write_byte;
    initial begin
        REG_WR = 1'b0;
        REG_ADDR = 9'h000;
        REG_WDATA = 8'h00;
    end
    task automatic write_reg(input logic [8:0] addr, input logic [7:0] data);
        @(posedge REF_CLK);
        #1;
        REG_WR = 1'b1;
        REG_ADDR = addr;
        REG_WDATA = data;
        @(posedge REF_CLK);
        #1;
        REG_WR = 1'b0;
        // Released lines carry the inverse, never a stale copy
        REG_ADDR = ~addr;
        REG_WDATA = ~data;
    endtask
    function automatic logic [1:0] pick(input logic odd, film, prog, input logic [1:0] sel);
        if (prog) begin
            return fmpc_pkg::OFFS_ZERO;
        end
        if (film) begin
            return (sel == 2'h0) ? fmpc_pkg::OFFS_PLUS :
                (sel == 2'h1) ? fmpc_pkg::OFFS_ZERO : fmpc_pkg::OFFS_MINUS;
        end
        return odd ? fmpc_pkg::OFFS_MINUS : fmpc_pkg::OFFS_PLUS;
    endfunction
    task automatic program_field(input logic odd, film, prog, input logic [7:0] rnd);
        logic swap;
        logic fill;
        // Swap only in film with the third memory fitted; embrace is set elsewhere
        swap = film & rnd[2];
        fill = ~(film & rnd[3]);
        path_byte = {pick(odd, film, prog, rnd[1:0]), swap, odd, rnd[4], 3'h0};
        write_byte = {2'h0, pick(odd, film, prog, rnd[3:2]), fill, rnd[7:5]};
        write_reg(fmpc_pkg::ADDR_PATH_CONTROL, path_byte);
        write_reg(fmpc_pkg::ADDR_FIELD_MEMORY_WRITE_CONTROL, write_byte);
        // Unmapped neighbour; must not disturb either register
        write_reg(9'h029, rnd);
    endtask
endmodule

// ---- tb/field_memory_path_control_tb.sv ----
/* Self-checking bench for the field memory path control block: the software model
   programs each field, the driver queues expected outputs, a monitor compares them.
   Assumes outputs follow inputs with one register stage. */
`timescale 1ns/100ps
module field_memory_path_control_tb;
    logic REF_CLK, ARST_N, REG_WR, FIELD_START, PROGRESSIVE, PIX_VALID, EST_VALID;
    logic [8:0] REG_ADDR;
    logic [7:0] REG_WDATA, FM2_RD_LUMA, FM3_RD_LUMA, FM1_LINE, FRAME_LINE, EST_DATA;
    fmpc_pkg::pixel_t DEINT_PIX, FM2_WR_PIX, FM3_WR_PIX;
    logic NEW_FIELD_FLAG, FM2_WE, FM3_WE, LEFT_PARITY, FIRST_ODD, TPM_WE;
    logic [7:0] LEFT_TREE_DATA, RIGHT_TREE_DATA, TPM_WR_DATA;
    logic [1:0] VEC_OFFSET, DNR_OFFSET;
    logic [65:0] seen;
    logic [65:0] exp_q[$];
    logic nf;
    int n_mismatch = 0;
    int cmp_count = 0;
    assign seen = {NEW_FIELD_FLAG, FM2_WE, FM2_WR_PIX, FM3_WE, FM3_WR_PIX, LEFT_TREE_DATA,
        RIGHT_TREE_DATA, VEC_OFFSET, DNR_OFFSET, LEFT_PARITY, FIRST_ODD, TPM_WE, TPM_WR_DATA};
    control_software sw (.REF_CLK(REF_CLK), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA));
    field_memory_path_control uut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .REG_WR(REG_WR),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .FIELD_START(FIELD_START),
        .PROGRESSIVE(PROGRESSIVE), .PIX_VALID(PIX_VALID), .DEINT_PIX(DEINT_PIX),
        .FM2_RD_LUMA(FM2_RD_LUMA), .FM3_RD_LUMA(FM3_RD_LUMA), .FM1_LINE(FM1_LINE),
        .FRAME_LINE(FRAME_LINE), .EST_VALID(EST_VALID), .EST_DATA(EST_DATA),
        .NEW_FIELD_FLAG(NEW_FIELD_FLAG), .FM2_WE(FM2_WE), .FM2_WR_PIX(FM2_WR_PIX),
        .FM3_WE(FM3_WE), .FM3_WR_PIX(FM3_WR_PIX), .LEFT_TREE_DATA(LEFT_TREE_DATA),
        .RIGHT_TREE_DATA(RIGHT_TREE_DATA), .VEC_OFFSET(VEC_OFFSET), .DNR_OFFSET(DNR_OFFSET),
        .LEFT_PARITY(LEFT_PARITY), .FIRST_ODD(FIRST_ODD), .TPM_WE(TPM_WE),
        .TPM_WR_DATA(TPM_WR_DATA));
    initial begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end
    function automatic logic [65:0] calc(input logic [7:0] pc, wc);
        fmpc_pkg::path_ctl_t p;
        fmpc_pkg::write_ctl_t w;
        p = pc;
        w = wc;
        return {nf, PIX_VALID & p.combined_memory_write_enable,
            w.original_memory_luma_update ? DEINT_PIX.luma : FM2_RD_LUMA, DEINT_PIX.chroma,
            PIX_VALID & p.combined_memory_write_enable,
            w.interpolated_memory_luma_update ? DEINT_PIX.luma : FM3_RD_LUMA,
            DEINT_PIX.chroma, p.line_tree_swap ? FRAME_LINE : FM1_LINE,
            p.line_tree_swap ? FM1_LINE : FRAME_LINE, p.vertical_vector_offset,
            w.noise_reduction_vertical_offset, w.left_tree_parity,
            p.first_memory_odd_parity, EST_VALID & w.prediction_fill, EST_DATA};
    endfunction
    task automatic apply(input logic [7:0] pc, wc);
        @(posedge REF_CLK);
        #1;
        {PIX_VALID, EST_VALID, EST_DATA} = 10'($urandom);
        DEINT_PIX = 16'($urandom);
        {FM2_RD_LUMA, FM3_RD_LUMA} = 16'($urandom);
        {FM1_LINE, FRAME_LINE} = 16'($urandom);
        exp_q.push_back(calc(pc, wc));
    endtask
    always @(posedge REF_CLK) begin
        if (exp_q.size() > 0) begin
            #2;
            cmp_count++;
            if (seen !== exp_q[0]) begin
                $display("[FAIL] outputs expected %h seen %h", exp_q[0], seen);
                n_mismatch++;
            end
            void'(exp_q.pop_front());
        end
    end
    task automatic give_verdict;
        if (exp_q.size() != 0) begin
            $display("[FAIL] pending results expected 0 seen %0d", exp_q.size());
            n_mismatch++;
        end
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        logic [7:0] opc, owc;
        logic prog;
        {ARST_N, FIELD_START, PROGRESSIVE, PIX_VALID, EST_VALID} = 5'h00;
        {EST_DATA, FM2_RD_LUMA, FM3_RD_LUMA, FM1_LINE, FRAME_LINE} = 40'h0;
        DEINT_PIX = 16'h0000;
        nf = fmpc_pkg::NEW_FIELD_RESET;
        opc = fmpc_pkg::PATH_CONTROL_RESET;
        owc = fmpc_pkg::WRITE_CONTROL_RESET;
        void'($urandom(85089));
        repeat (12) @(posedge REF_CLK);
        #1 ARST_N = 1'b1;
        for (int i = 0; i < 12; i++) begin
            if (i == 6) begin
                // Mid-run reset clears both registers and the field flag; let the
                // last queued result be compared before reset clears the outputs
                repeat (2) @(posedge REF_CLK);
                #1 ARST_N = 1'b0;
                repeat (2) @(posedge REF_CLK);
                cmp_count++;
                if (seen !== 66'h0) begin
                    $display("[FAIL] reset outputs expected 0 seen %h", seen);
                    n_mismatch++;
                end
                #1 ARST_N = 1'b1;
                {nf, opc, owc} = 17'h0;
            end
            prog = 1'($urandom);
            sw.program_field(1'($urandom), 1'($urandom), prog, 8'($urandom));
            PROGRESSIVE = prog;
            // Shadowed bytes must not take effect before the field edge
            repeat (3) apply(opc, owc);
            @(posedge REF_CLK);
            #1 FIELD_START = 1'b1;
            repeat (3) @(posedge REF_CLK);
            #1 FIELD_START = 1'b0;
            nf = prog ? 1'b1 : ~nf;
            repeat (8) @(posedge REF_CLK);
            opc = sw.path_byte;
            owc = sw.write_byte;
            repeat (6) apply(opc, owc);
        end
        repeat (3) @(posedge REF_CLK);
        give_verdict();
    end
endmodule
